// >>> hdl/ssh_host_port.sv
// Purpose: Serial host port of a weighing indicator: mode select, commands, report output.
// Assumes: Scale state inputs and keys are synchronous; keys are one-cycle pulses.
// Notes:   Reports are sent as hexadecimal digits, one line per weight value.
//
// How it works
// - Full duplex serial port at 1200, 2400, 4800 or 9600 baud.
// - Frames: 8N1, 7 odd 1 stop, 7 even 1 stop, 7N2.
// - Demand mode: transmit code demand, ticket off; output only on request.
// - In demand mode the print key also starts a transmission.
// - P sends the displayed reading unless moving or overloaded.
// - Z zeroes only when stable, in gross, within the zero range.
// - T takes a tare only when stable and gross is not negative.
// - G returns to gross only from net and when stable.
// - N goes to net only from gross, with a tare, when stable.
// - C advances to the next configured unit, wrapping around.
// - Ticket mode when the ticket setting is one: fixed-layout ticket.
// - In ticket mode the receive pin is clear-to-send; pause while low.
// - Tare and net lines appear only when a tare exists.
// - The identification line is left out when its enable is off.
// - Continuous mode: transmit code continuous, ticket off, no request needed.
// - Continuous mode sends one report at each display update that finds the sequencer idle.
// - Update rate follows span gain: 25 gives about 27 per second.
// - The front-panel zero key obeys the same conditions as Z.
`timescale 1ns/100ps
`default_nettype none
`include "ssh_regs.svh"

module ssh_host_port #(
   parameter int unsigned BIT_CYC_MAX       = `SSH_CLK_HZ / `SSH_BAUD_MAX,
   parameter int unsigned MEAS_CYC_PER_GAIN = `SSH_CLK_HZ / (`SSH_MEAS_RATE_25 * `SSH_GAIN_REF),
   parameter int unsigned NUM_UNITS         = 2
) (
   input  wire logic        I_CLK,
   input  wire logic        I_RESET_N,
   input  wire logic [7:0]  I_ADDR,
   input  wire logic [31:0] I_WDATA,
   input  wire logic        I_WR,
   input  wire logic        I_RD,
   output logic [31:0]      O_RDATA,
   input  wire logic        I_RXD,
   output logic             O_TXD,
   input  wire logic        I_MOTION,
   input  wire logic        I_OVER_POS,
   input  wire logic        I_OVER_NEG,
   input  wire logic [23:0] I_GROSS,
   input  wire logic        I_PRINT_KEY,
   input  wire logic        I_ZERO_KEY,
   output logic             O_ZERO_PULSE,
   output logic             O_NET_MODE,
   output logic             O_TARE_VALID,
   output logic [1:0]       O_UNIT,
   output logic             O_MEAS_TICK,
   output logic             O_TX_BUSY
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0]  ctrl_q, ctrl_d;
   logic [7:0]  span_q, span_d;
   logic [23:0] zr_q,   zr_d;
   logic [23:0] id_q,   id_d;
   logic [31:0] rd_q,   rd_d;
   logic [23:0] tare_q, tare_d;
   logic        net_q,  net_d;
   logic        tv_q,   tv_d;
   logic [1:0]  unit_q, unit_d;
   ssh_pkg::ssh_seq_t st_q, st_d;

   logic ticket, cont, demand;

   assign ticket = ctrl_q[`SSH_CTRL_TICKET];
   assign cont   = !ticket && ctrl_q[`SSH_CTRL_CONT];
   assign demand = !ticket && !ctrl_q[`SSH_CTRL_CONT];

   always_comb begin
      ctrl_d = ctrl_q;
      span_d = span_q;
      zr_d   = zr_q;
      id_d   = id_q;
      rd_d   = 32'h00000000;
      if (I_WR) begin
         case (I_ADDR)
            `SSH_ADDR_CTRL:   ctrl_d = I_WDATA[7:0];
            `SSH_ADDR_SPAN:   span_d = I_WDATA[7:0];
            `SSH_ADDR_ZRANGE: zr_d   = I_WDATA[23:0];
            `SSH_ADDR_ID:     id_d   = I_WDATA[23:0];
            default:          ctrl_d = ctrl_q;
         endcase
      end
      if (I_RD) begin
         case (I_ADDR)
            `SSH_ADDR_CTRL:   rd_d = {24'h000000, ctrl_q};
            `SSH_ADDR_SPAN:   rd_d = {24'h000000, span_q};
            `SSH_ADDR_ZRANGE: rd_d = {8'h00, zr_q};
            `SSH_ADDR_ID:     rd_d = {8'h00, id_q};
            `SSH_ADDR_STATUS: rd_d = {26'h0, I_RXD, st_q != ssh_pkg::SEQ_IDLE,
                                      unit_q, tv_q, net_q};
            `SSH_ADDR_TARE:   rd_d = {8'h00, tare_q};
            default:          rd_d = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ctrl_q <= `SSH_CTRL_RST;
         span_q <= `SSH_SPAN_RST;
         zr_q   <= `SSH_ZRANGE_RST;
         id_q   <= `SSH_ID_RST;
         rd_q   <= 32'h00000000;
      end else begin
         ctrl_q <= ctrl_d;
         span_q <= span_d;
         zr_q   <= zr_d;
         id_q   <= id_d;
         rd_q   <= rd_d;
      end
   end

   assign O_RDATA = rd_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Serial port and display update timing.

   logic [19:0] bit_cyc;
   logic        rx_vld, tx_rdy, tx_go;
   logic [7:0]  rx_dat, tx_dat;
   logic [31:0] meas_q, meas_d, meas_lim;
   logic        tick_q, tick_d;
   logic [7:0]  span_eff;

   // Slower rates are the top rate divided by a power of two, so one divisor suffices.
   assign bit_cyc = 20'(BIT_CYC_MAX) << (2'd3 - ctrl_q[`SSH_CTRL_BAUD_HI:`SSH_CTRL_BAUD_LO]);

   ssh_uart_rx u_rx (
      .i_clk     (I_CLK),
      .i_reset_n (I_RESET_N),
      .i_bit_cyc (bit_cyc),
      .i_fmt     (ssh_pkg::ssh_fmt_t'(ctrl_q[`SSH_CTRL_FMT_HI:`SSH_CTRL_FMT_LO])),
      .i_rxd     (I_RXD),
      .o_valid   (rx_vld),
      .o_data    (rx_dat)
   );

   ssh_uart_tx u_tx (
      .i_clk     (I_CLK),
      .i_reset_n (I_RESET_N),
      .i_bit_cyc (bit_cyc),
      .i_fmt     (ssh_pkg::ssh_fmt_t'(ctrl_q[`SSH_CTRL_FMT_HI:`SSH_CTRL_FMT_LO])),
      .i_go      (tx_go),
      .i_data    (tx_dat),
      .o_ready   (tx_rdy),
      .o_txd     (O_TXD)
   );

   // A zero gain would stall the update clock, so it runs as a gain of one.
   assign span_eff = (span_q == 8'h00) ? 8'h01 : span_q;
   assign meas_lim = 32'(span_eff) * 32'(MEAS_CYC_PER_GAIN) - 32'h00000001;

   always_comb begin
      tick_d = 1'b0;
      meas_d = meas_q + 32'h00000001;
      if (meas_q >= meas_lim) begin
         meas_d = 32'h00000000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         meas_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else begin
         meas_q <= meas_d;
         tick_q <= tick_d;
      end
   end

   assign O_MEAS_TICK = tick_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Command decoding and scale state.

   logic        stable, cmd_en, in_range, print_req, zero_ok;
   logic        zero_q, zero_d;
   logic [23:0] g_abs;

   assign stable   = !I_MOTION && !I_OVER_POS && !I_OVER_NEG;
   assign cmd_en   = rx_vld && demand;
   assign g_abs    = I_GROSS[23] ? (24'h000000 - I_GROSS) : I_GROSS;
   assign in_range = g_abs <= zr_q;
   assign zero_ok  = stable && !net_q && in_range;
   assign print_req = stable && ((cmd_en && rx_dat == `SSH_CH_P) || (I_PRINT_KEY && !cont));

   always_comb begin
      net_d  = net_q;
      tv_d   = tv_q;
      tare_d = tare_q;
      unit_d = unit_q;
      zero_d = (I_ZERO_KEY || (cmd_en && rx_dat == `SSH_CH_Z)) && zero_ok;
      if (cmd_en) begin
         case (rx_dat)
            `SSH_CH_T: begin
               if (stable && !I_GROSS[23]) begin
                  tv_d   = 1'b1;
                  tare_d = I_GROSS;
                  net_d  = 1'b1;
               end
            end
            `SSH_CH_G: if (net_q && stable) net_d = 1'b0;
            `SSH_CH_N: if (!net_q && tv_q && stable) net_d = 1'b1;
            `SSH_CH_C: unit_d = (32'(unit_q) >= NUM_UNITS - 1) ? 2'h0 : unit_q + 2'h1;
            default:   unit_d = unit_q;
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         net_q  <= 1'b0;
         tv_q   <= 1'b0;
         tare_q <= 24'h000000;
         unit_q <= 2'h0;
         zero_q <= 1'b0;
      end else begin
         net_q  <= net_d;
         tv_q   <= tv_d;
         tare_q <= tare_d;
         unit_q <= unit_d;
         zero_q <= zero_d;
      end
   end

   assign O_ZERO_PULSE = zero_q;
   assign O_NET_MODE   = net_q;
   assign O_TARE_VALID = tv_q;
   assign O_UNIT       = unit_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Report sequencer. Lines: 0 identification, 1 gross, 2 tare, 3 net.

   logic [1:0]  line_q, line_d;
   logic [3:0]  idx_q,  idx_d;
   logic        tkt_q,  tkt_d;
   logic        stv_q,  stv_d;
   logic [23:0] sg_q,   sg_d;
   logic [23:0] val;
   logic [3:0]  nib;
   logic [7:0]  label;

   always_comb begin
      case (line_q)
         2'h0:    begin val = id_q;          label = `SSH_CH_I; end
         2'h1:    begin val = sg_q;          label = `SSH_CH_G; end
         2'h2:    begin val = tare_q;        label = `SSH_CH_T; end
         default: begin val = sg_q - tare_q; label = `SSH_CH_N; end
      endcase
      nib = 4'(val >> {3'd6 - idx_q[2:0], 2'b00});
      case (idx_q)
         4'h0:    tx_dat = label;
         4'h7:    tx_dat = (unit_q == 2'h0) ? `SSH_CH_L : `SSH_CH_K;
         4'h8:    tx_dat = `SSH_CH_CR;
         4'h9:    tx_dat = `SSH_CH_LF;
         default: tx_dat = (nib < 4'ha) ? {4'h3, nib} : 8'(nib) + 8'h37;
      endcase
   end

   assign tx_go = (st_q == ssh_pkg::SEQ_CHAR) && tx_rdy && (!tkt_q || I_RXD);

   always_comb begin
      st_d   = st_q;
      line_d = line_q;
      idx_d  = idx_q;
      tkt_d  = tkt_q;
      stv_d  = stv_q;
      sg_d   = sg_q;
      case (st_q)
         ssh_pkg::SEQ_IDLE: begin
            if (print_req || (cont && tick_q)) begin
               st_d   = ssh_pkg::SEQ_CHAR;
               tkt_d  = ticket;
               stv_d  = tv_q;
               sg_d   = I_GROSS;
               idx_d  = 4'h0;
               if (ticket) begin
                  line_d = ctrl_q[`SSH_CTRL_IDEN] ? 2'h0 : 2'h1;
               end else begin
                  line_d = net_q ? 2'h3 : 2'h1;
               end
            end
         end
         ssh_pkg::SEQ_CHAR: begin
            if (tx_go) st_d = ssh_pkg::SEQ_WAIT;
         end
         ssh_pkg::SEQ_WAIT: begin
            if (tx_rdy) begin
               st_d  = ssh_pkg::SEQ_CHAR;
               idx_d = idx_q + 4'h1;
               if (idx_q == `SSH_LAST_IDX) begin
                  idx_d = 4'h0;
                  if (!tkt_q || line_q == 2'h3 || (line_q == 2'h1 && !stv_q)) begin
                     st_d = ssh_pkg::SEQ_IDLE;
                  end else begin
                     line_d = line_q + 2'h1;
                  end
               end
            end
         end
         default: st_d = ssh_pkg::SEQ_IDLE;
      endcase
   end

   always_ff @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_q   <= ssh_pkg::SEQ_IDLE;
         line_q <= 2'h1;
         idx_q  <= 4'h0;
         tkt_q  <= 1'b0;
         stv_q  <= 1'b0;
         sg_q   <= 24'h000000;
      end else begin
         st_q   <= st_d;
         line_q <= line_d;
         idx_q  <= idx_d;
         tkt_q  <= tkt_d;
         stv_q  <= stv_d;
         sg_q   <= sg_d;
      end
   end

   assign O_TX_BUSY = st_q != ssh_pkg::SEQ_IDLE;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);

   sequence s_zero_cmd;
      cmd_en && rx_dat == `SSH_CH_Z && stable && !net_q && in_range;
   endsequence

   a_zero_gate_ok:    assert property (s_zero_cmd |=> O_ZERO_PULSE)
      else $error("Valid zero command gave no zero pulse");
   a_zero_key_cond:   assert property (O_ZERO_PULSE |-> $past(zero_ok))
      else $error("Zero pulse without its conditions");
   a_print_blocked:   assert property (rx_vld && !stable && st_q == ssh_pkg::SEQ_IDLE && !cont
                                       |=> st_q == ssh_pkg::SEQ_IDLE)
      else $error("Report started while scale unstable");
   a_demand_quiet:    assert property (demand && !print_req && st_q == ssh_pkg::SEQ_IDLE
                                       |=> st_q == ssh_pkg::SEQ_IDLE)
      else $error("Demand mode sent without request");
   a_key_prints:      assert property (demand && I_PRINT_KEY && stable
                                       && st_q == ssh_pkg::SEQ_IDLE |=> O_TX_BUSY)
      else $error("Print key started no report");
   a_tare_gate:       assert property ($rose(O_TARE_VALID) |-> $past(stable && !I_GROSS[23]))
      else $error("Tare taken under a bad condition");
   a_gross_gate:      assert property ($fell(O_NET_MODE) |-> $past(stable && rx_dat == `SSH_CH_G))
      else $error("Gross mode entered wrongly");
   a_net_gate:        assert property ($rose(O_NET_MODE) |-> $past(stable))
      else $error("Net mode entered while unstable");
   a_unit_wraps:      assert property (cmd_en && rx_dat == `SSH_CH_C && 32'(unit_q) == NUM_UNITS - 1
                                       |=> O_UNIT == 2'h0)
      else $error("Unit did not wrap");
   a_cts_pause:       assert property (tkt_q && !I_RXD |-> !tx_go)
      else $error("Ticket character sent while printer busy");
   a_ticket_no_tare:  assert property (O_TX_BUSY && tkt_q && !stv_q |-> line_q < 2'h2)
      else $error("Tare line printed without a tare");
   a_ticket_no_id:    assert property ($rose(O_TX_BUSY) && ticket && !ctrl_q[`SSH_CTRL_IDEN]
                                       |-> line_q == 2'h1)
      else $error("Ticket began with a disabled id line");
   a_cont_update:     assert property (cont && tick_q && st_q == ssh_pkg::SEQ_IDLE
                                       |=> O_TX_BUSY ##1 st_q != ssh_pkg::SEQ_IDLE)
      else $error("Update did not start a report");
   a_meas_period:     assert property (tick_q |-> meas_q == 32'h00000000 ##1 !tick_q)
      else $error("Update tick misplaced");
   a_other_ignored:   assert property (cmd_en && !(rx_dat inside {`SSH_CH_P, `SSH_CH_Z, `SSH_CH_T,
                                       `SSH_CH_G, `SSH_CH_N, `SSH_CH_C}) && !I_ZERO_KEY
                                       |=> $stable({net_q, tv_q, unit_q}) && !O_ZERO_PULSE)
      else $error("Unknown character changed state");

endmodule : ssh_host_port

`default_nettype wire

// >>> pkg/ssh_regs.svh
// Purpose: Offsets, field positions, reset values and timing figures of the host port.
// Assumes: A 100 MHz system clock.
// Notes:   Included by bare name wherever the values are needed.
`ifndef SSH_REGS_SVH
`define SSH_REGS_SVH

`define SSH_CLK_HZ        100000000
`define SSH_BAUD_MAX      9600
`define SSH_MEAS_RATE_25  27
`define SSH_GAIN_REF      25

`define SSH_ADDR_CTRL     8'h00
`define SSH_ADDR_SPAN     8'h04
`define SSH_ADDR_ZRANGE   8'h08
`define SSH_ADDR_ID       8'h0c
`define SSH_ADDR_STATUS   8'h10
`define SSH_ADDR_TARE     8'h14

`define SSH_CTRL_BAUD_LO  0
`define SSH_CTRL_BAUD_HI  1
`define SSH_CTRL_FMT_LO   2
`define SSH_CTRL_FMT_HI   3
`define SSH_CTRL_CONT     4
`define SSH_CTRL_TICKET   5
`define SSH_CTRL_IDEN     6

`define SSH_CTRL_RST      8'h03
`define SSH_SPAN_RST      8'h19
`define SSH_ZRANGE_RST    24'h000064
`define SSH_ID_RST        24'h000000

`define SSH_CH_P          8'h50
`define SSH_CH_Z          8'h5a
`define SSH_CH_T          8'h54
`define SSH_CH_G          8'h47
`define SSH_CH_N          8'h4e
`define SSH_CH_C          8'h43
`define SSH_CH_I          8'h49
`define SSH_CH_L          8'h4c
`define SSH_CH_K          8'h4b
`define SSH_CH_CR         8'h0d
`define SSH_CH_LF         8'h0a
`define SSH_LAST_IDX      4'h9

`endif

// >>> pkg/ssh_pkg.sv
// Purpose: Types shared by the host port modules.
// Assumes: Nothing beyond the register header.
// Notes:   Encodings are written out so that register fields map directly.
package ssh_pkg;

   typedef enum logic [1:0] {
      FMT_8N1 = 2'b00,
      FMT_7O1 = 2'b01,
      FMT_7E1 = 2'b10,
      FMT_7N2 = 2'b11
   } ssh_fmt_t;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CHAR = 2'b01,
      SEQ_WAIT = 2'b10
   } ssh_seq_t;

endpackage : ssh_pkg

// >>> hdl/ssh_uart_tx.sv
// Purpose: Serial character transmitter for the host port.
// Assumes: i_bit_cyc holds one bit time in clock cycles and stays put during a character.
// Notes:   Every format is ten bit times long, so one shifter serves them all.
`timescale 1ns/100ps
`default_nettype none

module ssh_uart_tx (
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire logic [19:0]      i_bit_cyc,
   input  wire ssh_pkg::ssh_fmt_t i_fmt,
   input  wire logic             i_go,
   input  wire logic [7:0]       i_data,
   output logic                  o_ready,
   output logic                  o_txd
);

   logic [9:0]  sh_q,   sh_d;
   logic [3:0]  nbit_q, nbit_d;
   logic [19:0] cnt_q,  cnt_d;
   logic        busy_q, busy_d;
   logic        b8;

   always_comb begin
      case (i_fmt)
         ssh_pkg::FMT_8N1: b8 = i_data[7];
         ssh_pkg::FMT_7O1: b8 = ~(^i_data[6:0]);
         ssh_pkg::FMT_7E1: b8 = ^i_data[6:0];
         default:          b8 = 1'b1;
      endcase
      sh_d   = sh_q;
      nbit_d = nbit_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      if (!busy_q) begin
         if (i_go) begin
            sh_d   = {1'b1, b8, i_data[6:0], 1'b0};
            nbit_d = 4'h9;
            cnt_d  = i_bit_cyc - 20'h00001;
            busy_d = 1'b1;
         end
      end else if (cnt_q == 20'h00000) begin
         sh_d = {1'b1, sh_q[9:1]};
         if (nbit_q == 4'h0) begin
            busy_d = 1'b0;
         end else begin
            nbit_d = nbit_q - 4'h1;
            cnt_d  = i_bit_cyc - 20'h00001;
         end
      end else begin
         cnt_d = cnt_q - 20'h00001;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sh_q   <= 10'h3ff;
         nbit_q <= 4'h0;
         cnt_q  <= 20'h00000;
         busy_q <= 1'b0;
      end else begin
         sh_q   <= sh_d;
         nbit_q <= nbit_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
      end
   end

   assign o_ready = !busy_q;
   assign o_txd   = sh_q[0];

endmodule : ssh_uart_tx

`default_nettype wire

// >>> hdl/ssh_uart_rx.sv
// Purpose: Serial character receiver for the host port.
// Assumes: The line idles high and is synchronous to the clock.
// Notes:   Characters with a bad start, stop or parity bit are dropped silently.
`timescale 1ns/100ps
`default_nettype none

module ssh_uart_rx (
   input  wire logic             i_clk,
   input  wire logic             i_reset_n,
   input  wire logic [19:0]      i_bit_cyc,
   input  wire ssh_pkg::ssh_fmt_t i_fmt,
   input  wire logic             i_rxd,
   output logic                  o_valid,
   output logic [7:0]            o_data
);

   logic [8:0]  sh_q,   sh_d;
   logic [3:0]  nbit_q, nbit_d;
   logic [19:0] cnt_q,  cnt_d;
   logic        busy_q, busy_d;
   logic        vld_q,  vld_d;
   logic [7:0]  dat_q,  dat_d;
   logic        good;

   always_comb begin
      sh_d   = sh_q;
      nbit_d = nbit_q;
      cnt_d  = cnt_q;
      busy_d = busy_q;
      vld_d  = 1'b0;
      dat_d  = dat_q;
      good   = 1'b0;
      if (!busy_q) begin
         if (!i_rxd) begin
            // Half a bit time lands every later sample in mid bit.
            cnt_d  = {1'b0, i_bit_cyc[19:1]};
            nbit_d = 4'h0;
            busy_d = 1'b1;
         end
      end else if (cnt_q == 20'h00000) begin
         cnt_d = i_bit_cyc - 20'h00001;
         if (nbit_q == 4'h0) begin
            busy_d = !i_rxd;
            nbit_d = 4'h1;
         end else begin
            sh_d   = {i_rxd, sh_q[8:1]};
            nbit_d = nbit_q + 4'h1;
            if (nbit_q == 4'h9) begin
               busy_d = 1'b0;
               case (i_fmt)
                  ssh_pkg::FMT_8N1: good = i_rxd;
                  ssh_pkg::FMT_7O1: good = i_rxd && (^sh_q[8:1]);
                  ssh_pkg::FMT_7E1: good = i_rxd && !(^sh_q[8:1]);
                  default:          good = i_rxd && sh_q[8];
               endcase
               vld_d = good;
               dat_d = (i_fmt == ssh_pkg::FMT_8N1) ? sh_q[8:1] : {1'b0, sh_q[7:1]};
            end
         end
      end else begin
         cnt_d = cnt_q - 20'h00001;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sh_q   <= 9'h000;
         nbit_q <= 4'h0;
         cnt_q  <= 20'h00000;
         busy_q <= 1'b0;
         vld_q  <= 1'b0;
         dat_q  <= 8'h00;
      end else begin
         sh_q   <= sh_d;
         nbit_q <= nbit_d;
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         vld_q  <= vld_d;
         dat_q  <= dat_d;
      end
   end

   assign o_valid = vld_q;
   assign o_data  = dat_q;

endmodule : ssh_uart_rx

`default_nettype wire

// >>> verification/ssh_host_model.sv
// Purpose: Host computer at the far side of the serial port.
// Assumes: 8N1 framing, bit time of BIT clock cycles.
// Notes:   Received characters are queued in rx_q for the bench.
`timescale 1ns/100ps
`default_nettype none

module ssh_host_model #(
   parameter int BIT = 16
) (
   input  wire logic i_clk,
   input  wire logic i_txd,
   output logic      o_rxd
);
   logic [7:0] rx_q[$];
   logic [7:0] sh;

   initial o_rxd = 1'b1;

   // The line idles high between characters, as its pull-up would leave it.
   task automatic send_char(input logic [7:0] c);
      for (int i = 0; i < 10; i++) begin
         o_rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[i-1];
         repeat (BIT) @(posedge i_clk);
      end
   endtask : send_char

   // Samples at bit centres so that edge jitter of one cycle is harmless.
   always begin
      @(negedge i_txd);
      repeat (BIT + BIT / 2) @(posedge i_clk);
      for (int i = 0; i < 8; i++) begin
         sh[i] = i_txd;
         repeat (BIT) @(posedge i_clk);
      end
      rx_q.push_back(sh);
   end
endmodule : ssh_host_model
`default_nettype wire

// >>> verification/testbench.sv
// Purpose: Self-checking bench for the serial host port.
// Assumes: Reset register values, 9600 baud scaled to 16 cycles a bit.
// Notes:   Each scenario task drives the port and judges the result.
`timescale 1ns/100ps
`default_nettype none

module testbench;
   logic        clk = 0, reset_n = 0, wr = 0, rd = 0;
   logic        motion = 0, over_pos = 0, over_neg = 0, print_key = 0, zero_key = 0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [23:0] gross = 24'h000032;
   logic        txd, rxd, zero_pulse, net_mode, tare_valid, meas_tick, tx_busy;
   logic [1:0]  unit;
   int          fail_count = 0, check_count = 0, zcnt = 0;

   always #5 clk = ~clk;
   always @(posedge clk) if (zero_pulse === 1'b1) zcnt++;

   ssh_host_model #(.BIT(16)) host (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));

   ssh_host_port #(.BIT_CYC_MAX(16), .MEAS_CYC_PER_GAIN(4), .NUM_UNITS(2)) dut (
      .I_CLK(clk), .I_RESET_N(reset_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .I_RXD(rxd), .O_TXD(txd), .I_MOTION(motion),
      .I_OVER_POS(over_pos), .I_OVER_NEG(over_neg), .I_GROSS(gross),
      .I_PRINT_KEY(print_key), .I_ZERO_KEY(zero_key), .O_ZERO_PULSE(zero_pulse),
      .O_NET_MODE(net_mode), .O_TARE_VALID(tare_valid), .O_UNIT(unit),
      .O_MEAS_TICK(meas_tick), .O_TX_BUSY(tx_busy));

   //////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rreg(input logic [7:0] a);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 d = rdata;
   endtask : rreg

   task automatic wreg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) begin addr <= a; wdata <= v; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
   endtask : wreg

   // Waits for the text from the port, compares it, then waits for the port to go idle.
   task automatic expect_text(input string s);
      int n = 0;
      while (host.rx_q.size() < s.len() && n < 6000) begin @(posedge clk); n++; end
      chk(n < 6000, 1'b1);
      for (int i = 0; i < s.len() && host.rx_q.size() > 0; i++) chk(host.rx_q.pop_front(), s[i]);
      n = 0;
      while (tx_busy !== 1'b0 && n < 100) begin @(posedge clk); n++; end
      chk(n < 100, 1'b1);
   endtask : expect_text

   // The command takes effect well before the stop bit has finished.
   task automatic cmd(input logic [7:0] c);
      host.send_char(c);
      repeat (4) @(posedge clk);
   endtask : cmd

   //////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      rreg(8'h00); chk(d, 32'h03);
      rreg(8'h20); chk(d, 32'h0);
      wreg(8'h10, 32'h1f);
      rreg(8'h10); chk(d, 32'h20);
   endtask : t_regs

   task automatic t_cmds;
      motion <= 1'b1; cmd(8'h54); chk(tare_valid, 1'b0);
      motion <= 1'b0; gross <= 24'hfffffb; cmd(8'h54); chk(tare_valid, 1'b0);
      gross <= 24'h000032; cmd(8'h47); chk(net_mode, 1'b0);
      cmd(8'h58); chk({net_mode, tare_valid, unit}, 4'h0);
      cmd(8'h54); chk({net_mode, tare_valid}, 2'b11);
      cmd(8'h5a); chk(zcnt, 0);
      over_pos <= 1'b1; cmd(8'h47); chk(net_mode, 1'b1);
      over_pos <= 1'b0; cmd(8'h47); chk(net_mode, 1'b0);
      cmd(8'h4e); chk(net_mode, 1'b1);
      cmd(8'h47); cmd(8'h5a); chk(zcnt, 1);
      gross <= 24'h0000c8; cmd(8'h5a); chk(zcnt, 1);
      @(posedge clk) zero_key <= 1'b1;
      @(posedge clk) zero_key <= 1'b0;
      repeat (3) @(posedge clk); chk(zcnt, 1);
      gross <= 24'h000032;
      @(posedge clk) zero_key <= 1'b1;
      @(posedge clk) zero_key <= 1'b0;
      repeat (3) @(posedge clk); chk(zcnt, 2);
   endtask : t_cmds

   task automatic t_unit;
      cmd(8'h43); chk(unit, 2'd1);
      cmd(8'h43); chk(unit, 2'd0);
   endtask : t_unit

   task automatic t_print;
      motion <= 1'b1; cmd(8'h50); chk(tx_busy, 1'b0);
      motion <= 1'b0; cmd(8'h50); chk(tx_busy, 1'b1);
      expect_text("G000032L\r\n");
      @(posedge clk) print_key <= 1'b1;
      @(posedge clk) print_key <= 1'b0;
      #1 chk(tx_busy, 1'b1);
      expect_text("G000032L\r\n");
   endtask : t_print

   // The printer holds its ready line low at first, so the ticket must wait for it.
   task automatic t_ticket;
      wreg(8'h00, 32'h23);
      host.o_rxd <= 1'b0;
      @(posedge clk) print_key <= 1'b1;
      @(posedge clk) print_key <= 1'b0;
      repeat (50) @(posedge clk);
      chk({tx_busy, txd}, 2'b11);
      host.o_rxd <= 1'b1;
      expect_text("G000032L\r\nT000032L\r\nN000000L\r\n");
   endtask : t_ticket

   // Continuous mode needs no request: a display update starts a report.
   task automatic t_cont;
      int n = 0;
      wreg(8'h00, 32'h13);
      while (tx_busy !== 1'b1 && n < 1000) begin @(posedge clk); n++; end
      chk(n < 1000, 1'b1);
      expect_text("G000032L\r\n");
      // A span gain of 25 at 4 cycles per gain step puts updates 100 cycles apart.
      n = 0;
      do begin @(posedge clk); n++; end while (meas_tick !== 1'b1 && n < 200);
      n = 0;
      do begin @(posedge clk); n++; end while (meas_tick !== 1'b1 && n < 200);
      chk(n, 100);
   endtask : t_cont

   //////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_cmds();
      t_unit();
      t_print();
      t_ticket();
      t_cont();
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
